// >>> diag_pkg.sv
// Functional notes
// - Log an event only when mask bit set.
// - Ten-bit mask split over two bytes.
// - First-fault record ten bits, mask layout.
// - Last and cumulative records packed across bytes.
// - First fault stored once, never overwritten.
// - Last fault overwritten by each new fault.
// - Cumulative record ORs every logged class.
// - Enter test mode only with mode bit0.
// - Mode bit2 picks RAM, else reread EEPROM.
// - Test exit aborts transmission immediately.
// - Half-bit clock 780 ns fast, 3.125 us slow; code gives 15 and 62 clocks, 750 ns and 3.1 us.
// - Manchester bits drive low-side sink on/off.
// - Zero is off-to-on, one is on-to-off.
// - Frame is start one, eight bits, pause.
// - Data bits go out MSB first.
// - Mode code selects transmitted address ranges.
// - Reload EEPROM on exit if bits1:0 nonzero.
// - Full reload in three modes, else 0x00-0x31; code takes full reload from full_reload_mode_i alone, whatever the mode.
// - Test entry aborts read-in, repeat afterwards.
// - Target port answers only while enabled.
// - Missing EEPROM enables target, disables core.
// - Each received byte stored straight into RAM.
package diag_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int FAULT_W = 10;
	localparam logic [6:0] MASK_LO_ADDR = 7'h1B;
	localparam logic [6:0] MASK_HI_ADDR = 7'h1C;
	localparam int MODE_LSB = 4;
	localparam logic [6:0] FAULT_FIRST_ADDR = 7'h30;
	localparam logic [6:0] FAULT_LAST_ADDR = 7'h33;
	localparam logic [6:0] MEM_FIRST_ADDR = 7'h00;
	localparam logic [6:0] MEM_LAST_ADDR = 7'h7F;
	localparam logic [6:0] PARTIAL_LAST_ADDR = 7'h31;
	localparam logic [6:0] EE_OEM_FIRST_ADDR = 7'h24;
	localparam logic [6:0] RAM_OEM_FIRST_ADDR = 7'h3B;
	localparam logic [6:0] RAM_OEM_LAST_ADDR = 7'h43;
	localparam logic [9:0] MASK_RESET = 10'h000;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [9:0] FAULT_RESET = 10'h000;
	localparam logic CORE_EN_RESET = 1'b1;
	localparam logic [2:0] MODE_EE_OEM = 3'h1;
	localparam logic [2:0] MODE_RAM_OEM = 3'h5;
	localparam int CLK_PERIOD_NS = 50;
	localparam int FAST_HALF_NS = 780;
	localparam int SLOW_HALF_NS = 3125;
	localparam int FAST_HALF_CYCLES = FAST_HALF_NS / CLK_PERIOD_NS;
	localparam int SLOW_HALF_CYCLES = SLOW_HALF_NS / CLK_PERIOD_NS;
	localparam int NO_EE_TIMEOUT_MS = 150;
	localparam int NO_EE_TIMEOUT_CYCLES = NO_EE_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int FRAME_HALVES = 18;
	localparam int PAUSE_HALVES = 4;

	typedef enum logic [2:0] {SEQ_IDLE, SEQ_LOAD, SEQ_TX_ISSUE, SEQ_TX_RAM, SEQ_TX_EE, SEQ_TX_DONE} seq_state_type;
	typedef enum logic [1:0] {SER_IDLE, SER_BITS, SER_PAUSE} ser_state_type;
	typedef enum logic [1:0] {I2C_IDLE, I2C_ADDR, I2C_REG, I2C_DATA} i2c_state_type;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} mem_wr_type;
endpackage : diag_pkg

// >>> diag_ram.sv
`timescale 1ns/100ps
module diag_ram #(
	parameter int AW = diag_pkg::ADDR_W,
	parameter int DW = diag_pkg::DATA_W
) (
	input wire logic ref_clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic re_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge ref_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (re_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : diag_ram

// >>> diag_readout_and_fault_log.sv
`timescale 1ns/100ps
module diag_readout_and_fault_log #(
	parameter logic [6:0] TARGET_ADDR = 7'h2A, // Arbitrary value
	parameter int NO_EE_TIMEOUT_CYCLES = diag_pkg::NO_EE_TIMEOUT_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [9:0] fault_event_i,
	input wire logic test_entry_i,
	input wire logic test_exit_i,
	input wire logic fast_diag_clock_select_i,
	input wire logic full_reload_mode_i,
	input wire logic target_port_cfg_i,
	input wire logic core_enable_wr_i,
	input wire logic core_enable_val_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic ee_rd_o,
	output logic [6:0] ee_addr_o,
	input wire logic [7:0] ee_data_i,
	input wire logic ee_ack_i,
	input wire logic ee_nack_i,
	output logic fault_pin_o,
	output logic fault_pin_oe_o,
	output logic test_mode_o,
	output logic core_enable_o,
	output logic target_port_enable_o
);
	logic [9:0] fault_log_mask;
	logic [2:0] diag_mode_select;
	logic [9:0] first_fault_record;
	logic [9:0] last_fault_record;
	logic [9:0] cumulative_fault_record;
	logic [9:0] logged;
	logic test_mode;
	logic test_enter;
	logic test_leave;
	logic core_enable;
	logic target_forced;
	logic target_port_enable;
	logic drive_low;
	diag_pkg::seq_state_type seq_state;
	logic [6:0] seq_addr;
	logic reload_pend;
	logic ee_rd;
	logic [31:0] ee_wait;
	logic ee_fail;
	logic src_ram;
	logic [6:0] tx_first;
	logic [6:0] tx_last;
	logic [6:0] reload_last;
	logic ld_write;
	diag_pkg::mem_wr_type mem_wr;
	diag_pkg::mem_wr_type i2c_wr;
	logic ram_re;
	logic [7:0] ram_rdata;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic i2c_start;
	logic i2c_stop;
	diag_pkg::i2c_state_type i2c_state;
	logic [7:0] i2c_shift;
	logic [3:0] i2c_cnt;
	logic [6:0] i2c_ptr;
	logic i2c_ok;
	logic sda_oe;
	logic [7:0] buf_slot0;
	logic [7:0] buf_slot1;
	logic [1:0] buf_count;
	logic buf_in_valid;
	logic buf_in_ready;
	logic [7:0] buf_in_data;
	logic buf_out_valid;
	logic buf_out_ready;
	logic buf_flush;
	diag_pkg::ser_state_type ser_state;
	logic [8:0] ser_shift;
	logic [4:0] ser_half;
	logic [2:0] ser_pause;
	logic [6:0] div_cnt;
	logic [6:0] half_limit;
	logic div_tick;
	logic sink;

	function automatic logic is_fault_addr(input logic [6:0] a);
		is_fault_addr = (a >= diag_pkg::FAULT_FIRST_ADDR) && (a <= diag_pkg::FAULT_LAST_ADDR);
	endfunction : is_fault_addr

	function automatic logic [7:0] fault_byte(input logic [1:0] idx, input logic [9:0] f, input logic [9:0] l,
		input logic [9:0] c);
		unique case (idx)
			2'h0: fault_byte = f[7:0];
			2'h1: fault_byte = {l[5:0], f[9:8]};
			2'h2: fault_byte = {c[3:0], l[9:6]};
			2'h3: fault_byte = {2'h0, c[9:4]};
		endcase
	endfunction : fault_byte

	function automatic logic [6:0] next_tx_addr(input logic [6:0] a, input logic [2:0] m);
		if (m == diag_pkg::MODE_RAM_OEM && a == diag_pkg::FAULT_LAST_ADDR) begin
			next_tx_addr = diag_pkg::RAM_OEM_FIRST_ADDR;
		end else begin
			next_tx_addr = 7'(a + 7'h01);
		end
	endfunction : next_tx_addr

	assign logged = fault_event_i & fault_log_mask;
	assign test_enter = test_entry_i & diag_mode_select[0] & ~test_mode;
	assign test_leave = test_mode & test_exit_i;
	assign src_ram = diag_mode_select[2];
	assign reload_last = full_reload_mode_i ? diag_pkg::MEM_LAST_ADDR : diag_pkg::PARTIAL_LAST_ADDR;
	assign tx_last = (diag_mode_select == diag_pkg::MODE_RAM_OEM) ? diag_pkg::RAM_OEM_LAST_ADDR : diag_pkg::MEM_LAST_ADDR;

	always_comb begin
		unique case (diag_mode_select)
			diag_pkg::MODE_EE_OEM: tx_first = diag_pkg::EE_OEM_FIRST_ADDR;
			diag_pkg::MODE_RAM_OEM: tx_first = diag_pkg::FAULT_FIRST_ADDR;
			default: tx_first = diag_pkg::MEM_FIRST_ADDR;
		endcase
	end

	// Reload owns the write port; a target byte waits one cycle at most
	assign ld_write = (seq_state == diag_pkg::SEQ_LOAD) & ee_rd & ee_ack_i;

	always_comb begin
		if (ld_write) begin
			mem_wr = {1'b1, seq_addr, ee_data_i};
		end else begin
			mem_wr = i2c_wr;
		end
	end

	diag_ram u_ram (
		.ref_clk_i(ref_clk_i),
		.we_i(mem_wr.en),
		.waddr_i(mem_wr.addr),
		.wdata_i(mem_wr.data),
		.re_i(ram_re),
		.raddr_i(seq_addr),
		.rdata_o(ram_rdata)
	);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_log_mask <= diag_pkg::MASK_RESET;
			diag_mode_select <= diag_pkg::MODE_RESET;
		end else if (mem_wr.en) begin
			if (mem_wr.addr == diag_pkg::MASK_LO_ADDR) begin
				fault_log_mask[7:0] <= mem_wr.data;
			end
			if (mem_wr.addr == diag_pkg::MASK_HI_ADDR) begin
				fault_log_mask[9:8] <= mem_wr.data[1:0];
				diag_mode_select <= mem_wr.data[diag_pkg::MODE_LSB +: 3];
			end
		end
	end

	// Logged events land after a same-cycle write so a new fault is never lost
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_fault_record <= diag_pkg::FAULT_RESET;
			last_fault_record <= diag_pkg::FAULT_RESET;
			cumulative_fault_record <= diag_pkg::FAULT_RESET;
		end else begin
			if (mem_wr.en && is_fault_addr(mem_wr.addr)) begin
				unique case (mem_wr.addr[1:0])
					2'h0: first_fault_record[7:0] <= mem_wr.data;
					2'h1: begin
						first_fault_record[9:8] <= mem_wr.data[1:0];
						last_fault_record[5:0] <= mem_wr.data[7:2];
					end
					2'h2: begin
						last_fault_record[9:6] <= mem_wr.data[3:0];
						cumulative_fault_record[3:0] <= mem_wr.data[7:4];
					end
					2'h3: cumulative_fault_record[9:4] <= mem_wr.data[5:0];
				endcase
			end
			if (logged != 10'h000) begin
				if (first_fault_record == 10'h000) begin
					first_fault_record <= logged;
				end
				last_fault_record <= logged;
				cumulative_fault_record <= cumulative_fault_record | logged;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			test_mode <= 1'b0;
		end else if (test_leave) begin
			test_mode <= 1'b0;
		end else if (test_enter) begin
			test_mode <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ee_wait <= 32'h00000000;
		end else if (!ee_rd || ee_ack_i) begin
			ee_wait <= 32'h00000000;
		end else begin
			ee_wait <= 32'(ee_wait + 32'h00000001);
		end
	end

	assign ee_fail = ee_rd & (ee_nack_i | (ee_wait == 32'(NO_EE_TIMEOUT_CYCLES - 1)));

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			core_enable <= diag_pkg::CORE_EN_RESET;
			target_forced <= 1'b0;
			target_port_enable <= 1'b0;
		end else begin
			if (ee_fail) begin
				core_enable <= 1'b0;
				target_forced <= 1'b1;
			end else if (core_enable_wr_i) begin
				core_enable <= core_enable_val_i;
			end
			target_port_enable <= target_port_cfg_i | target_forced | ee_fail;
		end
	end

	// Power-up read-in is pending from reset
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			seq_state <= diag_pkg::SEQ_IDLE;
			seq_addr <= diag_pkg::MEM_FIRST_ADDR;
			reload_pend <= 1'b1;
			ee_rd <= 1'b0;
		end else if (ee_fail) begin
			seq_state <= diag_pkg::SEQ_IDLE;
			reload_pend <= 1'b0;
			ee_rd <= 1'b0;
		end else if (test_leave) begin
			seq_state <= diag_pkg::SEQ_IDLE;
			ee_rd <= 1'b0;
			if (diag_mode_select[1:0] != 2'h0) begin
				reload_pend <= 1'b1;
			end
		end else if (test_enter) begin
			if (seq_state == diag_pkg::SEQ_LOAD) begin
				reload_pend <= 1'b1;
			end
			seq_state <= diag_pkg::SEQ_TX_ISSUE;
			seq_addr <= tx_first;
			ee_rd <= 1'b0;
		end else begin
			unique case (seq_state)
				diag_pkg::SEQ_IDLE: begin
					if (reload_pend && !test_mode) begin
						seq_state <= diag_pkg::SEQ_LOAD;
						seq_addr <= diag_pkg::MEM_FIRST_ADDR;
						reload_pend <= 1'b0;
					end
				end
				diag_pkg::SEQ_LOAD: begin
					if (ee_rd && ee_ack_i) begin
						ee_rd <= 1'b0;
						if (seq_addr == reload_last) begin
							seq_state <= diag_pkg::SEQ_IDLE;
						end else begin
							seq_addr <= 7'(seq_addr + 7'h01);
						end
					end else begin
						ee_rd <= 1'b1;
					end
				end
				diag_pkg::SEQ_TX_ISSUE: begin
					if (buf_in_ready) begin
						if (src_ram) begin
							seq_state <= diag_pkg::SEQ_TX_RAM;
						end else begin
							seq_state <= diag_pkg::SEQ_TX_EE;
							ee_rd <= 1'b1;
						end
					end
				end
				diag_pkg::SEQ_TX_RAM: begin
					seq_state <= (seq_addr == tx_last) ? diag_pkg::SEQ_TX_DONE : diag_pkg::SEQ_TX_ISSUE;
					seq_addr <= next_tx_addr(seq_addr, diag_mode_select);
				end
				diag_pkg::SEQ_TX_EE: begin
					if (ee_ack_i) begin
						ee_rd <= 1'b0;
						seq_state <= (seq_addr == tx_last) ? diag_pkg::SEQ_TX_DONE : diag_pkg::SEQ_TX_ISSUE;
						seq_addr <= next_tx_addr(seq_addr, diag_mode_select);
					end
				end
				diag_pkg::SEQ_TX_DONE: begin
				end
			endcase
		end
	end

	assign ram_re = (seq_state == diag_pkg::SEQ_TX_ISSUE) & buf_in_ready & src_ram;
	assign buf_in_valid = (seq_state == diag_pkg::SEQ_TX_RAM) | ((seq_state == diag_pkg::SEQ_TX_EE) & ee_rd & ee_ack_i);

	// Live fault records stand in for the stale RAM copies
	always_comb begin
		if (seq_state == diag_pkg::SEQ_TX_EE) begin
			buf_in_data = ee_data_i;
		end else if (is_fault_addr(seq_addr)) begin
			buf_in_data = fault_byte(seq_addr[1:0], first_fault_record, last_fault_record, cumulative_fault_record);
		end else begin
			buf_in_data = ram_rdata;
		end
	end

	assign i2c_start = scl_i & scl_d & sda_d & ~sda_i;
	assign i2c_stop = scl_i & scl_d & ~sda_d & sda_i;
	assign scl_rise = scl_i & ~scl_d;
	assign scl_fall = ~scl_i & scl_d;
	assign i2c_ok = (i2c_state != diag_pkg::I2C_ADDR) ||
		((i2c_shift[7:1] == TARGET_ADDR) && !i2c_shift[0] && target_port_enable);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			i2c_state <= diag_pkg::I2C_IDLE;
			i2c_shift <= 8'h00;
			i2c_cnt <= 4'h0;
			i2c_ptr <= 7'h00;
			sda_oe <= 1'b0;
			i2c_wr <= '0;
		end else begin
			scl_d <= scl_i;
			sda_d <= sda_i;
			if (i2c_wr.en && !ld_write) begin
				i2c_wr.en <= 1'b0;
			end
			if (i2c_start) begin
				i2c_state <= diag_pkg::I2C_ADDR;
				i2c_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (i2c_stop) begin
				i2c_state <= diag_pkg::I2C_IDLE;
				i2c_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (i2c_state != diag_pkg::I2C_IDLE) begin
				if (scl_rise && i2c_cnt < 4'h8) begin
					i2c_shift <= {i2c_shift[6:0], sda_i};
					i2c_cnt <= 4'(i2c_cnt + 4'h1);
				end else if (scl_fall && i2c_cnt == 4'h8) begin
					if (i2c_ok) begin
						sda_oe <= 1'b1;
						i2c_cnt <= 4'h9;
						if (i2c_state == diag_pkg::I2C_REG) begin
							i2c_ptr <= i2c_shift[6:0];
						end
						if (i2c_state == diag_pkg::I2C_DATA) begin
							i2c_wr <= {1'b1, i2c_ptr, i2c_shift};
							i2c_ptr <= 7'(i2c_ptr + 7'h01);
						end
					end else begin
						i2c_state <= diag_pkg::I2C_IDLE;
					end
				end else if (scl_fall && i2c_cnt == 4'h9) begin
					sda_oe <= 1'b0;
					i2c_cnt <= 4'h0;
					i2c_state <= (i2c_state == diag_pkg::I2C_ADDR) ? diag_pkg::I2C_REG : diag_pkg::I2C_DATA;
				end
			end
		end
	end

	// Two-entry buffer: fetcher stalls on a busy serializer, nothing dropped
	assign buf_flush = ~test_mode | test_enter | test_leave;
	assign buf_in_ready = (buf_count != 2'h2);
	assign buf_out_valid = (buf_count != 2'h0);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_count <= 2'h0;
			buf_slot0 <= 8'h00;
			buf_slot1 <= 8'h00;
		end else if (buf_flush) begin
			buf_count <= 2'h0;
		end else begin
			unique case ({buf_in_valid & buf_in_ready, buf_out_valid & buf_out_ready})
				2'b10: begin
					if (buf_count == 2'h0) begin
						buf_slot0 <= buf_in_data;
					end else begin
						buf_slot1 <= buf_in_data;
					end
					buf_count <= 2'(buf_count + 2'h1);
				end
				2'b01: begin
					buf_slot0 <= buf_slot1;
					buf_count <= 2'(buf_count - 2'h1);
				end
				2'b11: begin
					if (buf_count == 2'h1) begin
						buf_slot0 <= buf_in_data;
					end else begin
						buf_slot0 <= buf_slot1;
						buf_slot1 <= buf_in_data;
					end
				end
				2'b00: begin
				end
			endcase
		end
	end

	assign buf_out_ready = test_mode & ~test_leave & (ser_state == diag_pkg::SER_IDLE);
	assign half_limit = fast_diag_clock_select_i ? 7'(diag_pkg::FAST_HALF_CYCLES) : 7'(diag_pkg::SLOW_HALF_CYCLES);
	assign div_tick = (div_cnt == 7'(half_limit - 7'h01));

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= 7'h00;
		end else if (ser_state == diag_pkg::SER_IDLE || div_tick) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= 7'(div_cnt + 7'h01);
		end
	end

	// Level moves only on a half-cell tick, apart from frame start and abort
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ser_state <= diag_pkg::SER_IDLE;
			ser_shift <= 9'h000;
			ser_half <= 5'h00;
			ser_pause <= 3'h0;
			sink <= 1'b0;
		end else if (!test_mode || test_leave) begin
			ser_state <= diag_pkg::SER_IDLE;
			sink <= 1'b0;
		end else begin
			unique case (ser_state)
				diag_pkg::SER_IDLE: begin
					if (buf_out_valid) begin
						ser_shift <= {1'b1, buf_slot0};
						ser_half <= 5'h00;
						ser_state <= diag_pkg::SER_BITS;
						sink <= 1'b1;
					end
				end
				diag_pkg::SER_BITS: begin
					if (div_tick) begin
						if (ser_half == 5'(diag_pkg::FRAME_HALVES - 1)) begin
							ser_state <= diag_pkg::SER_PAUSE;
							ser_pause <= 3'h0;
							sink <= 1'b0;
						end else begin
							ser_half <= 5'(ser_half + 5'h01);
							if (ser_half[0]) begin
								ser_shift <= {ser_shift[7:0], 1'b0};
								sink <= ser_shift[7];
							end else begin
								sink <= ~ser_shift[8];
							end
						end
					end
				end
				diag_pkg::SER_PAUSE: begin
					if (div_tick) begin
						if (ser_pause == 3'(diag_pkg::PAUSE_HALVES - 1)) begin
							ser_state <= diag_pkg::SER_IDLE;
						end else begin
							ser_pause <= 3'(ser_pause + 3'h1);
						end
					end
				end
				default: begin
					ser_state <= diag_pkg::SER_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_low <= 1'b0;
		end else begin
			drive_low <= 1'b0;
		end
	end

	assign sda_o = drive_low;
	assign sda_oe_o = sda_oe;
	assign fault_pin_o = drive_low;
	assign fault_pin_oe_o = sink;
	assign ee_rd_o = ee_rd;
	assign ee_addr_o = seq_addr;
	assign test_mode_o = test_mode;
	assign core_enable_o = core_enable;
	assign target_port_enable_o = target_port_enable;
endmodule : diag_readout_and_fault_log

// >>> diag_readout_monitor.sv
`timescale 1ns/100ps
module diag_readout_monitor (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic test_entry_i,
	input wire logic test_exit_i,
	input wire logic fast_diag_clock_select_i,
	input wire logic target_port_cfg_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic ee_rd_o,
	input wire logic [6:0] ee_addr_o,
	input wire logic ee_ack_i,
	input wire logic ee_nack_i,
	input wire logic fault_pin_o,
	input wire logic fault_pin_oe_o,
	input wire logic test_mode_o,
	input wire logic core_enable_o,
	input wire logic target_port_enable_o
);
	logic prev_oe;
	logic [7:0] run_cnt;
	// Length of the current sink level, saturating
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_oe <= 1'b0;
			run_cnt <= 8'h00;
		end else begin
			prev_oe <= fault_pin_oe_o;
			if (fault_pin_oe_o != prev_oe) begin
				run_cnt <= 8'h01;
			end else if (run_cnt != 8'hFF) begin
				run_cnt <= run_cnt + 8'h01;
			end
		end
	end
	default clocking mon_cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	exit_abort_a: assert property (test_exit_i |=> !test_mode_o && !fault_pin_oe_o)
		else $error("test mode or sink kept after exit");
	entry_cause_a: assert property ($rose(test_mode_o) |-> $past(test_entry_i))
		else $error("test mode without entry request");
	// Only on-runs: off-runs include the pause and idle
	half_cell_a: assert property (prev_oe && !fault_pin_oe_o && test_mode_o |->
		run_cnt == (fast_diag_clock_select_i ? 8'h0F : 8'h3E) ||
		run_cnt == (fast_diag_clock_select_i ? 8'h1E : 8'h7C))
		else $error("sink on-run not one or two half cells");
	sink_only_a: assert property (fault_pin_oe_o |-> test_mode_o && !fault_pin_o)
		else $error("sink on outside test mode");
	ee_hold_a: assert property (ee_rd_o && !ee_ack_i && !ee_nack_i && !test_entry_i && !test_exit_i
		|=> ee_rd_o && $stable(ee_addr_o))
		else $error("read request dropped early");
	ee_drop_a: assert property (ee_rd_o && ee_ack_i |=> !ee_rd_o)
		else $error("read request not released after answer");
	// A switch between read-in and transmission restarts the address
	ee_ascend_a: assert property ($rose(ee_rd_o) && $past(ee_rd_o, 2) && $past(test_mode_o, 2) == test_mode_o |->
		ee_addr_o == $past(ee_addr_o, 2) + 7'h01)
		else $error("read-in address not ascending");
	no_ee_a: assert property (ee_rd_o && ee_nack_i |-> ##[1:3] !core_enable_o && target_port_enable_o)
		else $error("missing memory not handled");
	target_cfg_a: assert property ($past(rst_n_i) && $past(target_port_cfg_i) |-> target_port_enable_o)
		else $error("target port enable not following setting");
	ack_gate_a: assert property (sda_oe_o |-> target_port_enable_o && !sda_o)
		else $error("acknowledge while target port off");
endmodule : diag_readout_monitor

bind diag_readout_and_fault_log diag_readout_monitor u_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.test_entry_i(test_entry_i), .test_exit_i(test_exit_i), .fast_diag_clock_select_i(fast_diag_clock_select_i),
	.target_port_cfg_i(target_port_cfg_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .ee_rd_o(ee_rd_o),
	.ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i), .ee_nack_i(ee_nack_i), .fault_pin_o(fault_pin_o),
	.fault_pin_oe_o(fault_pin_oe_o), .test_mode_o(test_mode_o), .core_enable_o(core_enable_o),
	.target_port_enable_o(target_port_enable_o));

// >>> diag_eeprom_model.sv
`timescale 1ns/100ps
module diag_eeprom_model (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic ee_rd_i,
	input wire logic [6:0] ee_addr_i,
	input wire logic slow_i,
	input wire logic absent_i,
	output logic [7:0] ee_data_o,
	output logic ee_ack_o,
	output logic ee_nack_o
);
	logic [2:0] wait_cnt;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_cnt <= 3'h0;
			ee_ack_o <= 1'b0;
			ee_nack_o <= 1'b0;
			ee_data_o <= 8'h00;
		end else begin
			ee_ack_o <= 1'b0;
			ee_nack_o <= 1'b0;
			// Idle data toggles so a stale byte never looks valid
			ee_data_o <= ~ee_data_o;
			if (!ee_rd_i || ee_ack_o || ee_nack_o) begin
				wait_cnt <= slow_i ? 3'h6 : 3'h0;
			end else if (wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
			end else if (absent_i) begin
				ee_nack_o <= 1'b1;
			end else begin
				ee_ack_o <= 1'b1;
				// Config area reads zero, keeping mode and mask off
				ee_data_o <= (ee_addr_i >= 7'h34) ? {1'b1, ee_addr_i} : 8'h00;
			end
		end
	end
endmodule : diag_eeprom_model

// >>> diag_readout_and_fault_log_test.sv
`timescale 1ns/100ps
module diag_readout_and_fault_log_test;
	localparam logic [6:0] TGT = 7'h2A; // Arbitrary value
	logic clk = 1'b0, rst_n = 1'b0, entry = 1'b0, exit_l = 1'b0, fast = 1'b1, cfg = 1'b0;
	logic ce_wr = 1'b0, ce_val = 1'b0, scl = 1'b1, sda_drv = 1'b1, slow = 1'b1, absent = 1'b0;
	logic [9:0] ev = 10'h000;
	logic sda_out, sda_oe, ee_rd, ee_ack, ee_nack, fpin, fpin_oe, tmode, core_en, tgt_en;
	logic [6:0] ee_addr;
	logic [7:0] ee_data;
	int n_mismatch = 0;
	int checks = 0;
	// Open drain with pull-up
	wire logic sda = sda_drv & ~sda_oe;
	diag_readout_and_fault_log #(.TARGET_ADDR(TGT), .NO_EE_TIMEOUT_CYCLES(50)) DUT (.ref_clk_i(clk),
		.rst_n_i(rst_n), .fault_event_i(ev), .test_entry_i(entry), .test_exit_i(exit_l),
		.fast_diag_clock_select_i(fast), .full_reload_mode_i(1'b0), .target_port_cfg_i(cfg),
		.core_enable_wr_i(ce_wr), .core_enable_val_i(ce_val), .scl_i(scl), .sda_i(sda), .sda_o(sda_out),
		.sda_oe_o(sda_oe), .ee_rd_o(ee_rd), .ee_addr_o(ee_addr), .ee_data_i(ee_data), .ee_ack_i(ee_ack),
		.ee_nack_i(ee_nack), .fault_pin_o(fpin), .fault_pin_oe_o(fpin_oe), .test_mode_o(tmode),
		.core_enable_o(core_en), .target_port_enable_o(tgt_en));
	diag_eeprom_model u_ee (.ref_clk_i(clk), .rst_n_i(rst_n), .ee_rd_i(ee_rd), .ee_addr_i(ee_addr),
		.slow_i(slow), .absent_i(absent), .ee_data_o(ee_data), .ee_ack_o(ee_ack), .ee_nack_o(ee_nack));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic report_and_stop;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic timeout(input string what);
		n_mismatch++;
		$display("MISMATCH %s expected event seen none", what);
		report_and_stop();
	endtask : timeout
	task automatic i2c_bit(input logic b, output logic s);
		sda_drv = b;
		tick(4);
		scl = 1'b1;
		tick(2);
		s = sda;
		tick(2);
		scl = 1'b0;
		tick(4);
	endtask : i2c_bit
	task automatic i2c_write(input logic [6:0] a, input logic [15:0] d, input logic exp, input string nm);
		logic [7:0] by [4];
		logic s;
		by = '{{a, 1'b0}, 8'h1B, d[15:8], d[7:0]};
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b0;
		for (int k = 0; k < 4; k++) begin
			for (int j = 7; j >= 0; j--) i2c_bit(by[k][j], s);
			i2c_bit(1'b1, s);
			check(nm, 8'(exp), 8'(!s));
		end
		sda_drv = 1'b0;
		tick(4);
		scl = 1'b1;
		tick(4);
		sda_drv = 1'b1;
		tick(4);
	endtask : i2c_write
	task automatic rx_byte(input int h, output logic [8:0] v);
		logic h1;
		for (int i = 0; i < 400 && fpin_oe !== 1'b1; i++) tick(1);
		if (fpin_oe !== 1'b1) timeout("sink start");
		tick(h / 2);
		for (int k = 8; k >= 0; k--) begin
			h1 = fpin_oe;
			tick(h);
			check("half cell pair", 8'(!h1), 8'(fpin_oe));
			v[k] = h1;
			tick(h);
		end
		check("pause level", 8'h00, 8'(fpin_oe));
	endtask : rx_byte
	task automatic t_reset;
		check("reset core enable", 8'h01, 8'(core_en));
		check("reset outputs", 8'h00, 8'({tmode, fpin_oe, sda_oe, ee_rd}));
		rst_n = 1'b1;
		for (int i = 0; i < 2000 && !(ee_ack === 1'b1 && ee_addr === 7'h31); i++) tick(1);
		if (!(ee_ack === 1'b1 && ee_addr === 7'h31)) timeout("read-in end");
		tick(10);
		check("read-in stops at 0x31", 8'h00, 8'(ee_rd));
		$display("done reset and read-in");
	endtask : t_reset
	task automatic t_refusals;
		entry = 1'b1;
		tick(6);
		check("entry with mode bit0 clear", 8'h00, 8'(tmode));
		entry = 1'b0;
		cfg = 1'b1;
		tick(2);
		i2c_write(7'h2B, 16'h0352, 1'b0, "wrong address ack");
		cfg = 1'b0;
		tick(2);
		i2c_write(TGT, 16'h0352, 1'b0, "disabled port ack");
		$display("done refusals");
	endtask : t_refusals
	task automatic t_log_and_send;
		logic [9:0] evs [4];
		logic [9:0] f, l, c, m;
		logic [7:0] e [4];
		logic [8:0] v;
		evs = '{10'h004, 10'h001, 10'h002, 10'h200};
		f = 10'h000;
		l = 10'h000;
		c = 10'h000;
		m = 10'h203;
		cfg = 1'b1;
		tick(2);
		// Mode 101 with mask bits 2-8 written as zero
		i2c_write(TGT, 16'h0352, 1'b1, "program ack");
		for (int k = 0; k < 4; k++) begin
			ev = evs[k];
			tick(1);
			ev = 10'h000;
			tick(3);
			if ((evs[k] & m) != 10'h000) begin
				f = (f == 10'h000) ? (evs[k] & m) : f;
				l = evs[k] & m;
				c = c | (evs[k] & m);
			end
		end
		e = '{f[7:0], {l[5:0], f[9:8]}, {c[3:0], l[9:6]}, {2'b00, c[9:4]}};
		entry = 1'b1;
		tick(2);
		check("test mode entered", 8'h01, 8'(tmode));
		for (int k = 0; k < 4; k++) begin
			// Last frame at the slow rate; switched while the sink is off
			fast = (k < 3);
			rx_byte(fast ? diag_pkg::FAST_HALF_CYCLES : diag_pkg::SLOW_HALF_CYCLES, v);
			check("start bit", 8'h01, 8'(v[8]));
			check("record byte", e[k], (k == 3) ? {2'b00, v[5:0]} : v[7:0]);
		end
		$display("done fault log and transmission");
	endtask : t_log_and_send
	task automatic t_exit_reload;
		// Exit in mid-frame so the abort is visible
		for (int i = 0; i < 400 && fpin_oe !== 1'b1; i++) tick(1);
		check("frame running", 8'h01, 8'(fpin_oe));
		cfg = 1'b0;
		absent = 1'b1;
		entry = 1'b0;
		exit_l = 1'b1;
		tick(1);
		check("exit aborts", 8'h00, 8'({tmode, fpin_oe}));
		exit_l = 1'b0;
		for (int i = 0; i < 20 && ee_rd !== 1'b1; i++) tick(1);
		check("reload after exit", 8'h01, 8'(ee_rd));
		for (int i = 0; i < 80 && core_en !== 1'b0; i++) tick(1);
		check("no memory: core off, port on", 8'h01, 8'({core_en, tgt_en}));
		// Tooling restarts the core after programming
		ce_val = 1'b1;
		ce_wr = 1'b1;
		tick(1);
		ce_wr = 1'b0;
		tick(2);
		check("core re-enabled", 8'h01, 8'(core_en));
		$display("done exit and reload");
	endtask : t_exit_reload
	initial begin
		tick(10);
		t_reset();
		t_refusals();
		t_log_and_send();
		t_exit_reload();
		report_and_stop();
	end
endmodule : diag_readout_and_fault_log_test
